// file: common/cmp_timer_pkg.sv
package cmp_timer_pkg;

    // Bus and counter widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int NUM_CMP = 4;
    localparam int PRE_W = 3;
    localparam int DIV_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_IO_CONTROL_ONE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_OPTION_REG_ZERO = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_COMPARE_REG = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_COMPARE_REG_ONE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_COMPARE_REG_TWO = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_COMPARE_REG_THREE = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h2C;

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_EVT_BIT = 1;
    localparam int CTRL_PRE_LSB = 2;
    localparam int CTRL_PEND_BIT = 8;

    // Io control one fields: capture_edge_sel_lo / capture_edge_sel_hi
    localparam int EDGE_SEL_LO_BIT = 0;
    localparam int EDGE_SEL_HI_BIT = 1;

    // Option register zero fields
    localparam int OPT_INVERT_BIT = 0;

    // Compare channel indices
    localparam int CH_PERIOD = 0;
    localparam int CH_ONE = 1;
    localparam int CH_TWO = 2;
    localparam int CH_THREE = 3;

    // Reset values and unit constants
    localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
    localparam logic [DIV_W-1:0] RST_DIV = 8'h00;
    localparam logic [DIV_W:0] DIV_ONE = 9'h001;
    localparam logic [DATA_W-1:0] CNT_ONE = 16'h0001;

endpackage

// file: hdl/event_pin_sync.sv
module event_pin_sync (
    input logic clk_sys_i,
    input logic nrst_i,
    input logic pin_i,
    output logic rise_o,
    output logic fall_o
);

    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic level;

    // Three-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // Level accepted once the last two stages agree
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            rise_o <= (sync_b == sync_c) && sync_c && !level;
            fall_o <= (sync_b == sync_c) && !sync_c && level;
            if (sync_b == sync_c) begin
                level <= sync_c;
            end
        end
    end

endmodule

// file: hdl/buffered_compare_timer.sv
// Overview of operation
// R1 - Aux compare above period never matches
// R2 - Event mode: clear and irq after D0+1
// R3 - Event mode still buffers and matches channels 1-3
// R4 - Software masks channel 1-3 irqs in event mode
// R5 - Event clock only from event pin, edge 00
// R6 - Event mode ignores io control and option
// R7 - Compare register one write arms transfer
// R8 - Armed transfer happens at counter clear
// R9 - Period, then two and three, one last
// R10 - Duty change: two, three, then one
// R11 - Channel one duty: write one only
// R12 - Two/three duty: then rewrite one
// R13 - Period only: then rewrite one
// R14 - Wait period irq before rewriting compares
// R15 - Enable loads buffers from compare registers
//
// The placing of the registers and strobed register access were decided locally.
module buffered_compare_timer #(
    parameter int CNT_W = 16
) (
    input logic clk_sys_i,
    input logic nrst_i,
    input logic [cmp_timer_pkg::ADDR_W-1:0] addr_i,
    input logic [cmp_timer_pkg::DATA_W-1:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    output logic [cmp_timer_pkg::DATA_W-1:0] rdata_o,
    input logic event_input_pin_i,
    output logic pwm_out_one_o,
    output logic pwm_out_two_o,
    output logic pwm_out_three_o,
    output logic period_match_irq_o,
    output logic [cmp_timer_pkg::NUM_CMP-2:0] aux_match_irq_o,
    output logic irq_o
);

    localparam int NC = cmp_timer_pkg::NUM_CMP;

    // Software visible state
    logic count_en;
    logic event_mode;
    logic [cmp_timer_pkg::PRE_W-1:0] prescale;
    logic [1:0] edge_sel;
    logic out_invert;
    logic [CNT_W-1:0] cmp_reg [NC];
    logic [CNT_W-1:0] cmp_buf [NC];
    logic [CNT_W-1:0] counter;
    logic [CNT_W-1:0] capture;
    logic [NC-1:0] irq_status;
    logic [NC-1:0] irq_enable;
    logic transfer_armed;

    // Internal timing
    logic count_en_d;
    logic start;
    logic [cmp_timer_pkg::DIV_W-1:0] div_cnt;
    logic [cmp_timer_pkg::DIV_W-1:0] div_mask;
    logic div_hit;
    logic ev_rise;
    logic ev_fall;
    logic tick;
    logic period_clear;
    logic [NC-1:0] match;
    logic [NC-2:0] pwm_level;
    logic [NC-2:0] pwm_pin;

    // Bus decode strobes
    logic wr_ctrl;
    logic wr_cmp_one;
    logic wr_clear;

    assign wr_ctrl = wr_i && (addr_i == cmp_timer_pkg::ADDR_CTRL);
    assign wr_cmp_one = wr_i && (addr_i == cmp_timer_pkg::ADDR_COMPARE_REG_ONE);
    assign wr_clear = wr_i && (addr_i == cmp_timer_pkg::ADDR_IRQ_CLEAR);

    // Event pin synchroniser and edge detector
    event_pin_sync i_event_pin_sync (
        .clk_sys_i (clk_sys_i),
        .nrst_i (nrst_i),
        .pin_i (event_input_pin_i),
        .rise_o (ev_rise),
        .fall_o (ev_fall)
    );

    // Control, io control and option registers
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_en <= 1'b0;
            event_mode <= 1'b0;
            prescale <= '0;
            edge_sel <= '0;
            out_invert <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == cmp_timer_pkg::ADDR_CTRL) begin
                count_en <= wdata_i[cmp_timer_pkg::CTRL_EN_BIT];
                event_mode <= wdata_i[cmp_timer_pkg::CTRL_EVT_BIT];
                prescale <= wdata_i[cmp_timer_pkg::CTRL_PRE_LSB +: cmp_timer_pkg::PRE_W];
            end
            if (addr_i == cmp_timer_pkg::ADDR_IO_CONTROL_ONE) begin
                edge_sel[1] <= wdata_i[cmp_timer_pkg::EDGE_SEL_HI_BIT];
                edge_sel[0] <= wdata_i[cmp_timer_pkg::EDGE_SEL_LO_BIT];
            end
            if (addr_i == cmp_timer_pkg::ADDR_OPTION_REG_ZERO) begin
                out_invert <= wdata_i[cmp_timer_pkg::OPT_INVERT_BIT];
            end
        end
    end

    // Compare registers, written freely by software
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NC; i++) begin
                cmp_reg[i] <= CNT_W'(cmp_timer_pkg::RST_WORD);
            end
        end else if (wr_i) begin
            unique case (addr_i)
                cmp_timer_pkg::ADDR_PERIOD_COMPARE_REG: cmp_reg[cmp_timer_pkg::CH_PERIOD] <= CNT_W'(wdata_i);
                cmp_timer_pkg::ADDR_COMPARE_REG_ONE: cmp_reg[cmp_timer_pkg::CH_ONE] <= CNT_W'(wdata_i);
                cmp_timer_pkg::ADDR_COMPARE_REG_TWO: cmp_reg[cmp_timer_pkg::CH_TWO] <= CNT_W'(wdata_i);
                cmp_timer_pkg::ADDR_COMPARE_REG_THREE: cmp_reg[cmp_timer_pkg::CH_THREE] <= CNT_W'(wdata_i);
                default: begin
                end
            endcase
        end
    end

    // Start pulse on the rising edge of the count enable
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_en_d <= 1'b0;
        end else begin
            count_en_d <= count_en;
        end
    end

    assign start = count_en && !count_en_d;

    // Prescaler: one-cycle enable every 2^prescale clocks
    assign div_mask = cmp_timer_pkg::DIV_W'((cmp_timer_pkg::DIV_ONE << prescale) - cmp_timer_pkg::DIV_ONE);
    assign div_hit = (div_cnt == div_mask);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt <= cmp_timer_pkg::RST_DIV;
        end else if (!count_en || start || div_hit) begin
            div_cnt <= cmp_timer_pkg::RST_DIV;
        end else begin
            div_cnt <= div_cnt + cmp_timer_pkg::DIV_W'(1);
        end
    end

    // Count clock: event pin rising edge only in event mode, no other source
    assign tick = count_en && !start && (event_mode ? ev_rise : div_hit); // R5

    // Period match clears the counter after D0+1 counts
    assign period_clear = tick && (counter == cmp_buf[cmp_timer_pkg::CH_PERIOD]); // R2

    // Counter
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            counter <= '0;
        end else if (start) begin
            counter <= '0;
        end else if (period_clear) begin
            counter <= '0; // R2
        end else if (tick) begin
            counter <= counter + CNT_W'(1);
        end
    end

    // Transfer arming; a new write wins over the transfer that clears it
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            transfer_armed <= 1'b0;
        end else if (wr_cmp_one) begin
            transfer_armed <= 1'b1; // R7 R14
        end else if (period_clear || start) begin
            transfer_armed <= 1'b0; // R8
        end
    end

    // Shadow buffers: direct load at start, armed load at counter clear
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NC; i++) begin
                cmp_buf[i] <= CNT_W'(cmp_timer_pkg::RST_WORD);
            end
        end else if (start) begin
            for (int i = 0; i < NC; i++) begin
                cmp_buf[i] <= cmp_reg[i]; // R15
            end
        end else if (period_clear && transfer_armed) begin
            for (int i = 0; i < NC; i++) begin
                cmp_buf[i] <= cmp_reg[i]; // R8 R3
            end
        end
    end

    // Match detection and PWM level per auxiliary channel
    assign match[cmp_timer_pkg::CH_PERIOD] = period_clear;

    generate
        for (genvar k = 1; k < NC; k++) begin : g_aux
            logic in_range;
            logic start_range;

            // Above-period values never match and leave the output alone
            assign in_range = (cmp_buf[k] <= cmp_buf[cmp_timer_pkg::CH_PERIOD]); // R1
            assign start_range = (cmp_reg[k] <= cmp_reg[cmp_timer_pkg::CH_PERIOD]);
            assign match[k] = tick && in_range && (counter == cmp_buf[k]); // R1 R3

            // Level high from period start until the channel match; a new period judged on its own values
            always_ff @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pwm_level[k-1] <= 1'b0;
                end else if (!count_en) begin
                    pwm_level[k-1] <= 1'b0;
                end else if (start) begin
                    pwm_level[k-1] <= start_range;
                end else if (match[k]) begin
                    pwm_level[k-1] <= 1'b0; // R1
                end else if (period_clear && (transfer_armed ? start_range : in_range)) begin
                    pwm_level[k-1] <= 1'b1; // R1 R8
                end
            end

            // Pin held low in event mode and while stopped; inversion not applied there
            always_ff @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pwm_pin[k-1] <= 1'b0;
                end else if (event_mode || !count_en) begin
                    pwm_pin[k-1] <= 1'b0; // R6
                end else begin
                    pwm_pin[k-1] <= pwm_level[k-1] ^ out_invert;
                end
            end
        end
    endgenerate

    assign pwm_out_one_o = pwm_pin[cmp_timer_pkg::CH_ONE-1];
    assign pwm_out_two_o = pwm_pin[cmp_timer_pkg::CH_TWO-1];
    assign pwm_out_three_o = pwm_pin[cmp_timer_pkg::CH_THREE-1];

    // Capture on selected pin edge, only outside event mode
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            capture <= '0;
        end else if (count_en && !event_mode) begin // R6
            if ((edge_sel[0] && ev_rise) || (edge_sel[1] && ev_fall)) begin
                capture <= counter;
            end
        end
    end

    // Raw match pulses out
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            period_match_irq_o <= 1'b0;
            aux_match_irq_o <= '0;
        end else begin
            period_match_irq_o <= match[cmp_timer_pkg::CH_PERIOD]; // R2
            aux_match_irq_o <= match[NC-1:1]; // R3
        end
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~(wr_clear ? wdata_i[NC-1:0] : '0)) | match;
        end
    end

    // Enable register acts as the per-channel mask
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_enable <= '0;
        end else if (wr_i && (addr_i == cmp_timer_pkg::ADDR_IRQ_ENABLE)) begin
            irq_enable <= wdata_i[NC-1:0]; // R4
        end
    end

    // Level interrupt
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_enable);
        end
    end

    // Read data valid only in the cycle after the read strobe
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= cmp_timer_pkg::RST_WORD;
        end else if (!rd_i) begin
            rdata_o <= cmp_timer_pkg::RST_WORD;
        end else begin
            rdata_o <= cmp_timer_pkg::RST_WORD;
            unique case (addr_i)
                cmp_timer_pkg::ADDR_CTRL: begin
                    rdata_o[cmp_timer_pkg::CTRL_EN_BIT] <= count_en;
                    rdata_o[cmp_timer_pkg::CTRL_EVT_BIT] <= event_mode;
                    rdata_o[cmp_timer_pkg::CTRL_PRE_LSB +: cmp_timer_pkg::PRE_W] <= prescale;
                    rdata_o[cmp_timer_pkg::CTRL_PEND_BIT] <= transfer_armed;
                end
                cmp_timer_pkg::ADDR_IO_CONTROL_ONE: begin
                    rdata_o[cmp_timer_pkg::EDGE_SEL_HI_BIT] <= edge_sel[1];
                    rdata_o[cmp_timer_pkg::EDGE_SEL_LO_BIT] <= edge_sel[0];
                end
                cmp_timer_pkg::ADDR_OPTION_REG_ZERO: rdata_o[cmp_timer_pkg::OPT_INVERT_BIT] <= out_invert;
                cmp_timer_pkg::ADDR_PERIOD_COMPARE_REG:
                    rdata_o <= cmp_timer_pkg::DATA_W'(cmp_reg[cmp_timer_pkg::CH_PERIOD]);
                cmp_timer_pkg::ADDR_COMPARE_REG_ONE: rdata_o <= cmp_timer_pkg::DATA_W'(cmp_reg[cmp_timer_pkg::CH_ONE]);
                cmp_timer_pkg::ADDR_COMPARE_REG_TWO: rdata_o <= cmp_timer_pkg::DATA_W'(cmp_reg[cmp_timer_pkg::CH_TWO]);
                cmp_timer_pkg::ADDR_COMPARE_REG_THREE:
                    rdata_o <= cmp_timer_pkg::DATA_W'(cmp_reg[cmp_timer_pkg::CH_THREE]);
                cmp_timer_pkg::ADDR_COUNTER: rdata_o <= cmp_timer_pkg::DATA_W'(counter);
                cmp_timer_pkg::ADDR_CAPTURE: rdata_o <= cmp_timer_pkg::DATA_W'(capture);
                cmp_timer_pkg::ADDR_IRQ_STATUS: rdata_o[NC-1:0] <= irq_status;
                cmp_timer_pkg::ADDR_IRQ_ENABLE: rdata_o[NC-1:0] <= irq_enable;
                default: rdata_o <= cmp_timer_pkg::RST_WORD;
            endcase
        end
    end

endmodule

// file: test/buffered_compare_timer_asserts.sv
module timer_checker #(
    parameter int CNT_W = 16
) (
    input logic clk_sys_i,
    input logic nrst_i,
    input logic [7:0] addr_i,
    input logic [15:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    input logic [15:0] rdata_o,
    input logic event_input_pin_i,
    input logic pwm_out_one_o,
    input logic pwm_out_two_o,
    input logic pwm_out_three_o,
    input logic period_match_irq_o,
    input logic [2:0] aux_match_irq_o,
    input logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ctrl;
    logic inv;
    logic [3:0] ena;
    logic [15:0] per;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Shadow of what software wrote
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl <= 2'h0;
            inv <= 1'b0;
            ena <= 4'h0;
            per <= 16'h0000;
        end else if (wr_i) begin
            if (addr_i == cmp_timer_pkg::ADDR_CTRL) ctrl <= wdata_i[1:0];
            if (addr_i == cmp_timer_pkg::ADDR_OPTION_REG_ZERO) inv <= wdata_i[0];
            if (addr_i == cmp_timer_pkg::ADDR_IRQ_ENABLE) ena <= wdata_i[3:0];
            if (addr_i == cmp_timer_pkg::ADDR_PERIOD_COMPARE_REG) per <= wdata_i;
        end
    end
    AST_IRQ_PERIOD: assert property (period_match_irq_o && ena[0] |=> irq_o)
        else $error("irq low after enabled period match");
    AST_IRQ_AUX: assert property (|(aux_match_irq_o & ena[3:1]) |=> irq_o)
        else $error("irq low after enabled aux match");
    AST_IRQ_MASKED: assert property (ena == 4'h0 |=> !irq_o)
        else $error("irq high while all sources masked");
    AST_PINS_IDLE: assert property ($past(ctrl[1] || !ctrl[0]) |->
        {pwm_out_three_o, pwm_out_two_o, pwm_out_one_o} == 3'h0)
        else $error("pwm pin active in event mode or disabled");
    AST_EVT_PULSE: assert property (ctrl[1] && period_match_irq_o |=> !period_match_irq_o)
        else $error("period pulse longer than one cycle");
    AST_PIN_FALL: assert property (|aux_match_irq_o && !period_match_irq_o && ctrl == 2'h1 && !inv
        |=> !(|($past(aux_match_irq_o) & {pwm_out_three_o, pwm_out_two_o, pwm_out_one_o})))
        else $error("pwm pin high at its compare match");
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    AST_RD_PERIOD: assert property (rd_i && addr_i == cmp_timer_pkg::ADDR_PERIOD_COMPARE_REG
        |=> rdata_o == per)
        else $error("period register read back wrong");
endmodule

bind buffered_compare_timer timer_checker #(.CNT_W(CNT_W)) i_timer_checker (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_input_pin_i(event_input_pin_i),
    .pwm_out_one_o(pwm_out_one_o), .pwm_out_two_o(pwm_out_two_o),
    .pwm_out_three_o(pwm_out_three_o), .period_match_irq_o(period_match_irq_o),
    .aux_match_irq_o(aux_match_irq_o), .irq_o(irq_o));

// file: test/event_source.sv
module event_source (
    input wire logic clk_sys_i,
    input wire logic go_i,
    input wire logic [3:0] n_i,
    input wire logic [3:0] gap_i,
    output logic pin_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Burst of n pulses, gap stretches each phase
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_sys_i);
            if (go_i) begin
                busy_o <= 1'b1;
                repeat (n_i) begin
                    pin_o <= 1'b1;
                    repeat (gap_i + 4) @(posedge clk_sys_i);
                    pin_o <= 1'b0;
                    repeat (gap_i + 4) @(posedge clk_sys_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule

// file: test/buffered_compare_timer_test.sv
module buffered_compare_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i, nrst_i, wr_i, rd_i, pin, per_irq, irq_o, go, busy;
    logic pwm1, pwm2, pwm3;
    logic [7:0] addr_i;
    logic [15:0] wdata_i, rdata_o;
    logic [2:0] aux;
    logic [3:0] ev_n, ev_gap;
    int errors = 0;
    int total_checks = 0;

    buffered_compare_timer i_buffered_compare_timer (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .event_input_pin_i(pin), .pwm_out_one_o(pwm1), .pwm_out_two_o(pwm2),
        .pwm_out_three_o(pwm3), .period_match_irq_o(per_irq), .aux_match_irq_o(aux), .irq_o(irq_o));
    event_source i_event_source (.clk_sys_i(clk_sys_i), .go_i(go), .n_i(ev_n), .gap_i(ev_gap),
        .pin_o(pin), .busy_o(busy));

    // Clock
    always #20 clk_sys_i = ~clk_sys_i;

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(nm, rdata_o, e);
    endtask

    task automatic pulses(input logic [3:0] n, input logic [3:0] g);
        int k;
        @(posedge clk_sys_i);
        ev_n <= n;
        ev_gap <= g;
        go <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
        @(posedge clk_sys_i);
        k = 0;
        while (busy === 1'b1 && k < 500) begin
            @(posedge clk_sys_i);
            k++;
        end
        repeat (6) @(posedge clk_sys_i);
    endtask

    // Period length and high time of each pin over one period
    task automatic measure(input int len, input int h1, input int h2, input int h3);
        int n, a, b, c;
        n = 0;
        a = 0;
        b = 0;
        c = 0;
        @(negedge clk_sys_i);
        while (per_irq !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
            a += pwm1;
            b += pwm2;
            c += pwm3;
        end while (per_irq !== 1'b1 && n < 100);
        chk("period", 16'(n), 16'(len));
        chk("high one", 16'(a), 16'(h1));
        chk("high two", 16'(b), 16'(h2));
        chk("high three", 16'(c), 16'(h3));
    endtask

    task automatic t_reset;
        chk("outputs", 16'({irq_o, per_irq, aux, pwm3, pwm2, pwm1}), 16'h0000);
        rchk("ctrl", cmp_timer_pkg::ADDR_CTRL, 16'h0000);
        rchk("status", cmp_timer_pkg::ADDR_IRQ_STATUS, 16'h0000);
        wr(cmp_timer_pkg::ADDR_COUNTER, 16'h0005);
        rchk("counter ro", cmp_timer_pkg::ADDR_COUNTER, 16'h0000);
        rchk("clear wo", cmp_timer_pkg::ADDR_IRQ_CLEAR, 16'h0000);
        rchk("unmapped", 8'h30, 16'h0000);
        $display("t_reset done");
    endtask

    task automatic t_event;
        wr(cmp_timer_pkg::ADDR_IO_CONTROL_ONE, 16'h0000);
        wr(cmp_timer_pkg::ADDR_OPTION_REG_ZERO, 16'h0001);
        wr(cmp_timer_pkg::ADDR_PERIOD_COMPARE_REG, 16'h0002);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_ONE, 16'h0002);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_TWO, 16'h0001);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_THREE, 16'h0005);
        wr(cmp_timer_pkg::ADDR_IRQ_ENABLE, 16'h0001);
        wr(cmp_timer_pkg::ADDR_CTRL, 16'h0003);
        pulses(4'h2, 4'h0);
        rchk("count", cmp_timer_pkg::ADDR_COUNTER, 16'h0002);
        rchk("status aux", cmp_timer_pkg::ADDR_IRQ_STATUS, 16'h0004);
        chk("irq masked", 16'(irq_o), 16'h0000);
        chk("pins", 16'({pwm3, pwm2, pwm1}), 16'h0000);
        pulses(4'h1, 4'h6);
        rchk("count clr", cmp_timer_pkg::ADDR_COUNTER, 16'h0000);
        rchk("status per", cmp_timer_pkg::ADDR_IRQ_STATUS, 16'h0007);
        chk("irq", 16'(irq_o), 16'h0001);
        wr(cmp_timer_pkg::ADDR_IRQ_CLEAR, 16'h000F);
        rchk("status clr", cmp_timer_pkg::ADDR_IRQ_STATUS, 16'h0000);
        chk("irq clr", 16'(irq_o), 16'h0000);
        pulses(4'h3, 4'h0);
        rchk("status again", cmp_timer_pkg::ADDR_IRQ_STATUS, 16'h0007);
        rchk("capture", cmp_timer_pkg::ADDR_CAPTURE, 16'h0000);
        $display("t_event done");
    endtask

    task automatic t_pwm;
        wr(cmp_timer_pkg::ADDR_CTRL, 16'h0000);
        wr(cmp_timer_pkg::ADDR_OPTION_REG_ZERO, 16'h0000);
        wr(cmp_timer_pkg::ADDR_PERIOD_COMPARE_REG, 16'h0009);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_ONE, 16'h0003);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_TWO, 16'h0005);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_THREE, 16'h000C);
        wr(cmp_timer_pkg::ADDR_CTRL, 16'h0001);
        measure(10, 4, 6, 0);
        wr(cmp_timer_pkg::ADDR_PERIOD_COMPARE_REG, 16'h0004);
        rchk("idle", cmp_timer_pkg::ADDR_CTRL, 16'h0001);
        measure(10, 4, 6, 0);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_ONE, 16'h0003);
        rchk("armed", cmp_timer_pkg::ADDR_CTRL, 16'h0101);
        measure(5, 4, 0, 0);
        wr(cmp_timer_pkg::ADDR_PERIOD_COMPARE_REG, 16'h0007);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_TWO, 16'h0002);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_THREE, 16'h0006);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_ONE, 16'h0001);
        measure(8, 2, 3, 7);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_ONE, 16'h0004);
        measure(8, 5, 3, 7);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_TWO, 16'h0005);
        wr(cmp_timer_pkg::ADDR_COMPARE_REG_ONE, 16'h0004);
        measure(8, 5, 6, 7);
        $display("t_pwm done");
    endtask

    // Main sequence
    initial begin
        clk_sys_i = 1'b0;
        nrst_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        go = 1'b0;
        ev_n = 4'h0;
        ev_gap = 4'h0;
        repeat (5) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        t_reset;
        t_event;
        t_pwm;
        close_out;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        errors++;
        close_out;
    end
endmodule
